// *** inc/alxe_consts.vh ***
// Opcode encodings, flag bit positions, reset values and PC steps for the executor
`ifndef ALXE_CONSTS_VH
`define ALXE_CONSTS_VH
`define ALXE_OP_ROT_R 8'h03
`define ALXE_OP_SET_C 8'hd3
`define ALXE_OP_SET_BIT 8'hd2
`define ALXE_OP_SJUMP 8'h80
`define ALXE_OP_SUB_IND 7'h4b
`define ALXE_OP_SWAP 8'hc4
`define ALXE_OP_XCH_IND 7'h63
`define ALXE_OP_XCH_REG 5'h19
`define ALXE_OP_XCH_DIR 8'hc5
`define ALXE_OP_LOW_NIBBLE_EXCHANGE_IND 7'h6b
`define ALXE_OP_XOR_IMM 8'h64
`define ALXE_OP_XOR_IND 7'h33
`define ALXE_OP_XOR_REG 5'h0d
`define ALXE_OP_RET 8'h22
`define ALXE_PSW_C 7
`define ALXE_PSW_AC 6
`define ALXE_PSW_OV 2
`define ALXE_PSW_P 0
`define ALXE_PSW_RST 8'h00
`define ALXE_SP_RST 8'h07
`define ALXE_PC_RST 16'h0000
`define ALXE_ACC_RST 8'h00
`define ALXE_PC_STEP1 16'h0001
`define ALXE_PC_STEP2 16'h0002
`endif

// *** hw/alxe_ram.v ***
// Internal data memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module alxe_ram #(
   parameter AW = 8,
   parameter DW = 8
) (
   input wire ref_clk,
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [DW-1:0] wdata,
   input wire [AW-1:0] raddr,
   output reg [DW-1:0] rdata
);
   reg [DW-1:0] mem [0:(1<<AW)-1];
   integer k;
   // Power-up clear so first reads are defined
   initial begin
      for (k = 0; k < (1 << AW); k = k + 1) begin
         mem[k] = {DW{1'b0}};
      end
   end
   always @(posedge ref_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // alxe_ram
`default_nettype wire

// *** hw/alxe_exec.v ***
// Instruction executor for accumulator logic, exchange and jump subset
// Contract
// - Rotate accumulator right, bit 0 to 7
// - Set carry flag to one
// - Set addressed bit, two bytes
// - Short jump: PC plus two plus offset
// - Indirect subtract carry and byte from accumulator
// - Swap accumulator nibbles
// - Exchange accumulator with indirect byte
// - Exchange accumulator with working register
// - Exchange accumulator with direct address
// - Exchange low nibbles with indirect byte
// - XOR accumulator with immediate byte
// - XOR accumulator with indirect byte
// - XOR accumulator with working register
// - Return pops PC high then low
`timescale 1ns/1ps
`default_nettype none
`include "alxe_consts.vh"
module alxe_exec #(
   parameter AW = 8
) (
   input wire ref_clk,
   input wire rst_n,
   input wire instr_valid,
   input wire [7:0] opcode,
   input wire [7:0] operand,
   input wire [1:0] bank_sel,
   output wire instr_ready,
   output reg done_r,
   output reg [7:0] acc_r,
   output reg [7:0] psw_r,
   output reg [7:0] sp_r,
   output reg [15:0] pc_r,
   output reg [7:0] bit_addr_r,
   output reg bit_set_r,
   output reg [1:0] bytes_r,
   output reg [1:0] cycles_r
);
   localparam S_IDLE = 5'b00001;
   localparam S_FETCH = 5'b00010;
   localparam S_EXEC = 5'b00100;
   localparam S_POP_HI = 5'b01000;
   localparam S_POP_LO = 5'b10000;

   reg [4:0] state_r;
   reg [4:0] state_nxt;
   reg [7:0] op_r;
   reg [7:0] arg_r;
   reg [AW-1:0] raddr;
   reg [AW-1:0] waddr;
   reg [7:0] wdata;
   reg we;
   wire [7:0] rdata;
   reg [7:0] ptr_r;
   reg [7:0] acc_nxt;
   reg [7:0] psw_nxt;
   reg [15:0] pc_nxt;
   reg [7:0] sp_nxt;
   reg acc_chg;
   wire [7:0] reg_base;
   wire [8:0] diff;
   wire [4:0] diff_lo;
   wire [7:0] sub_in;
   wire sub_ov;

   alxe_ram #(.AW(AW), .DW(8)) u_ram (
      .ref_clk(ref_clk),
      .we(we),
      .waddr(waddr),
      .wdata(wdata),
      .raddr(raddr),
      .rdata(rdata)
   );

   assign instr_ready = (state_r == S_IDLE);
   assign reg_base = {3'b000, bank_sel, 3'b000};
   assign sub_in = rdata;
   // Borrow chain for subtract
   assign diff = {1'b0, acc_r} - {1'b0, sub_in} - {8'h00, psw_r[`ALXE_PSW_C]};
   assign diff_lo = {1'b0, acc_r[3:0]} - {1'b0, sub_in[3:0]}
      - {4'h0, psw_r[`ALXE_PSW_C]};
   assign sub_ov = (acc_r[7] ^ sub_in[7]) & (acc_r[7] ^ diff[7]);

   // Read address one cycle ahead of use, as read data is registered
   always @* begin
      raddr = {AW{1'b0}};
      if (state_r == S_IDLE) begin
         if (opcode == `ALXE_OP_XCH_DIR) begin
            raddr = operand[AW-1:0];
         end else if (opcode[7:3] == `ALXE_OP_XCH_REG || opcode[7:3] == `ALXE_OP_XOR_REG) begin
            raddr = reg_base[AW-1:0] | {{(AW-3){1'b0}}, opcode[2:0]};
         end else begin
            raddr = reg_base[AW-1:0] | {{(AW-1){1'b0}}, opcode[0]};
         end
      end else if (state_r == S_FETCH) begin
         if (op_r == `ALXE_OP_RET) begin
            raddr = sp_r[AW-1:0];
         end else begin
            raddr = rdata[AW-1:0];
         end
      end else if (state_r == S_POP_HI) begin
         raddr = sp_r[AW-1:0] - {{(AW-1){1'b0}}, 1'b1};
      end
   end

   // Execute step
   always @* begin
      acc_nxt = acc_r;
      psw_nxt = psw_r;
      pc_nxt = pc_r;
      sp_nxt = sp_r;
      acc_chg = 1'b0;
      we = 1'b0;
      waddr = {AW{1'b0}};
      wdata = 8'h00;
      state_nxt = state_r;
      case (state_r)
         S_IDLE: begin
            if (instr_valid) begin
               state_nxt = S_FETCH;
            end
         end
         S_FETCH: begin
            state_nxt = S_EXEC;
            if (op_r == `ALXE_OP_RET) begin
               state_nxt = S_POP_HI;
            end
         end
         S_EXEC: begin
            state_nxt = S_IDLE;
            if (op_r == `ALXE_OP_ROT_R) begin
               acc_nxt = {acc_r[0], acc_r[7:1]};
               acc_chg = 1'b1;
               pc_nxt = pc_r + `ALXE_PC_STEP1;
            end else if (op_r == `ALXE_OP_SET_C) begin
               psw_nxt[`ALXE_PSW_C] = 1'b1;
               pc_nxt = pc_r + `ALXE_PC_STEP1;
            end else if (op_r == `ALXE_OP_SET_BIT) begin
               pc_nxt = pc_r + `ALXE_PC_STEP2;
            end else if (op_r == `ALXE_OP_SJUMP) begin
               pc_nxt = pc_r + `ALXE_PC_STEP2 + {{8{arg_r[7]}}, arg_r};
            end else if (op_r[7:1] == `ALXE_OP_SUB_IND) begin
               acc_nxt = diff[7:0];
               acc_chg = 1'b1;
               psw_nxt[`ALXE_PSW_C] = diff[8];
               psw_nxt[`ALXE_PSW_AC] = diff_lo[4];
               psw_nxt[`ALXE_PSW_OV] = sub_ov;
               pc_nxt = pc_r + `ALXE_PC_STEP1;
            end else if (op_r == `ALXE_OP_SWAP) begin
               acc_nxt = {acc_r[3:0], acc_r[7:4]};
               acc_chg = 1'b1;
               pc_nxt = pc_r + `ALXE_PC_STEP1;
            end else if (op_r[7:1] == `ALXE_OP_XCH_IND) begin
               acc_nxt = rdata;
               acc_chg = 1'b1;
               we = 1'b1;
               waddr = ptr_r[AW-1:0];
               wdata = acc_r;
               pc_nxt = pc_r + `ALXE_PC_STEP1;
            end else if (op_r[7:3] == `ALXE_OP_XCH_REG || op_r == `ALXE_OP_XCH_DIR) begin
               acc_nxt = ptr_r;
               acc_chg = 1'b1;
               we = 1'b1;
               waddr = (op_r == `ALXE_OP_XCH_DIR) ? arg_r[AW-1:0]
                  : (reg_base[AW-1:0] | {{(AW-3){1'b0}}, op_r[2:0]});
               wdata = acc_r;
               pc_nxt = pc_r + ((op_r == `ALXE_OP_XCH_DIR) ? `ALXE_PC_STEP2 : `ALXE_PC_STEP1);
            end else if (op_r[7:1] == `ALXE_OP_LOW_NIBBLE_EXCHANGE_IND) begin
               acc_nxt = {acc_r[7:4], rdata[3:0]};
               acc_chg = 1'b1;
               we = 1'b1;
               waddr = ptr_r[AW-1:0];
               wdata = {rdata[7:4], acc_r[3:0]};
               pc_nxt = pc_r + `ALXE_PC_STEP1;
            end else if (op_r == `ALXE_OP_XOR_IMM) begin
               acc_nxt = acc_r ^ arg_r;
               acc_chg = 1'b1;
               pc_nxt = pc_r + `ALXE_PC_STEP2;
            end else if (op_r[7:1] == `ALXE_OP_XOR_IND) begin
               acc_nxt = acc_r ^ rdata;
               acc_chg = 1'b1;
               pc_nxt = pc_r + `ALXE_PC_STEP1;
            end else if (op_r[7:3] == `ALXE_OP_XOR_REG) begin
               acc_nxt = acc_r ^ ptr_r;
               acc_chg = 1'b1;
               pc_nxt = pc_r + `ALXE_PC_STEP1;
            end else begin
               pc_nxt = pc_r + `ALXE_PC_STEP1;
            end
            if (acc_chg) begin
               psw_nxt[`ALXE_PSW_P] = ^acc_nxt;
            end
         end
         S_POP_HI: begin
            pc_nxt = {rdata, pc_r[7:0]};
            sp_nxt = sp_r - 8'h01;
            state_nxt = S_POP_LO;
         end
         S_POP_LO: begin
            pc_nxt = {pc_r[15:8], rdata};
            sp_nxt = sp_r - 8'h01;
            state_nxt = S_IDLE;
         end
         default: begin
            state_nxt = S_IDLE;
         end
      endcase
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= S_IDLE;
         op_r <= 8'h00;
         arg_r <= 8'h00;
         ptr_r <= 8'h00;
         acc_r <= `ALXE_ACC_RST;
         psw_r <= `ALXE_PSW_RST;
         sp_r <= `ALXE_SP_RST;
         pc_r <= `ALXE_PC_RST;
         done_r <= 1'b0;
         bit_addr_r <= 8'h00;
         bit_set_r <= 1'b0;
         bytes_r <= 2'h0;
         cycles_r <= 2'h0;
      end else begin
         state_r <= state_nxt;
         acc_r <= acc_nxt;
         psw_r <= psw_nxt;
         sp_r <= sp_nxt;
         pc_r <= pc_nxt;
         done_r <= 1'b0;
         bit_set_r <= 1'b0;
         if (state_r == S_IDLE && instr_valid) begin
            op_r <= opcode;
            arg_r <= operand;
         end
         if (state_r == S_FETCH) begin
            ptr_r <= rdata;
         end
         if (state_r == S_EXEC && op_r == `ALXE_OP_SET_BIT) begin
            bit_addr_r <= arg_r;
            bit_set_r <= 1'b1;
         end
         if ((state_r == S_EXEC && op_r != `ALXE_OP_RET) || state_r == S_POP_LO) begin
            done_r <= 1'b1;
            bytes_r <= (op_r == `ALXE_OP_SET_BIT || op_r == `ALXE_OP_SJUMP
               || op_r == `ALXE_OP_XCH_DIR || op_r == `ALXE_OP_XOR_IMM) ? 2'h2 : 2'h1;
            cycles_r <= (op_r == `ALXE_OP_SJUMP || op_r == `ALXE_OP_RET) ? 2'h2 : 2'h1;
         end
      end
   end
endmodule // alxe_exec
`default_nettype wire

// *** tb/alxe_exec_properties.sv ***
// Port-level assertions for the executor
`timescale 1ns/1ps
`default_nettype none
module alxe_exec_props #(
   parameter AW = 8
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic instr_valid,
   input wire logic [7:0] opcode,
   input wire logic [7:0] operand,
   input wire logic [1:0] bank_sel,
   input wire logic instr_ready,
   input wire logic done_r,
   input wire logic [7:0] acc_r,
   input wire logic [7:0] psw_r,
   input wire logic [7:0] sp_r,
   input wire logic [15:0] pc_r,
   input wire logic [7:0] bit_addr_r,
   input wire logic bit_set_r,
   input wire logic [1:0] bytes_r,
   input wire logic [1:0] cycles_r
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire take = instr_valid && instr_ready;
   logic [7:0] op_r, d_r, a_r, p_r, s_r;
   logic [15:0] pct_r;
   // State seen when the instruction was taken
   always @(posedge ref_clk) begin
      if (take) begin
         {op_r, d_r, a_r, p_r, s_r, pct_r} <= {opcode, operand, acc_r, psw_r, sp_r, pc_r};
      end
   end
   rr_result_a: assert property (done_r && op_r == 8'h03 |-> acc_r == {a_r[0], a_r[7:1]})
      else $error("rotate result wrong");
   carry_set_a: assert property (done_r && op_r == 8'hd3 |-> psw_r == (p_r | 8'h80))
      else $error("carry set wrong");
   bit_report_a: assert property (take && opcode == 8'hd2 |-> ##[1:3] (bit_set_r && bit_addr_r == d_r))
      else $error("bit set not reported");
   sjump_pc_a: assert property (done_r && op_r == 8'h80 |-> pc_r == pct_r + 16'd2 + {{8{d_r[7]}}, d_r})
      else $error("short jump target wrong");
   nib_swap_a: assert property (done_r && op_r == 8'hc4 |-> acc_r == {a_r[3:0], a_r[7:4]})
      else $error("nibble swap wrong");
   xor_imm_a: assert property (done_r && op_r == 8'h64 |-> acc_r == (a_r ^ d_r))
      else $error("xor immediate wrong");
   ret_pop_a: assert property (take && opcode == 8'h22 |-> ##3 !done_r ##1 (done_r && sp_r == s_r - 8'd2))
      else $error("return timing or pointer wrong");
   parity_a: assert property (done_r |-> psw_r[0] == ^acc_r)
      else $error("parity flag wrong");
   flags_kept_a: assert property (done_r && op_r != 8'hd3 && op_r[7:1] != 7'h4b |-> psw_r[7:1] == p_r[7:1])
      else $error("flags changed");
   cover property (done_r && op_r == 8'h22);
   cover property (bit_set_r);
   cover property (done_r && op_r[7:1] == 7'h4b && psw_r[7]);
endmodule // alxe_exec_props
bind alxe_exec alxe_exec_props #(.AW(AW)) props_u (.ref_clk, .rst_n, .instr_valid, .opcode,
   .operand, .bank_sel, .instr_ready, .done_r, .acc_r, .psw_r, .sp_r, .pc_r, .bit_addr_r,
   .bit_set_r, .bytes_r, .cycles_r);
`default_nettype wire

// *** tb/tb_alxe_exec.sv ***
// Self-checking bench for the executor
`timescale 1ns/1ps
`default_nettype none
module tb_alxe_exec;
   logic ref_clk, rst_n, instr_valid;
   logic [7:0] opcode, operand, m_acc, m_psw, m_sp;
   logic [1:0] bank_sel;
   wire instr_ready, done_r, bit_set_r;
   wire [7:0] acc_r, psw_r, sp_r, bit_addr_r;
   wire [15:0] pc_r;
   wire [1:0] bytes_r, cycles_r;
   logic [7:0] mem [0:255];
   logic [15:0] m_pc;
   logic [43:0] expq [$];
   logic [43:0] e;
   int error_cnt, check_count, i;
   alxe_exec dut_u (.ref_clk, .rst_n, .instr_valid, .opcode, .operand, .bank_sel,
      .instr_ready, .done_r, .acc_r, .psw_r, .sp_r, .pc_r, .bit_addr_r, .bit_set_r,
      .bytes_r, .cycles_r);
   task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
      if (!$isunknown(ex)) begin
         check_count++;
         if (got !== ex) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, ex, got);
         end
      end
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Model one instruction, note the result, then issue it
   task automatic run(input logic [7:0] op, input logic [7:0] opd);
      logic [7:0] t, p;
      logic [8:0] s;
      logic [4:0] h;
      logic [1:0] nb, nc;
      @(negedge ref_clk);
      if ($isunknown(m_acc))
         m_acc = acc_r;
      p = mem[{3'b000, bank_sel, 2'b00, op[0]}];
      t = mem[{3'b000, bank_sel, op[2:0]}];
      nb = 2'd1;
      nc = 2'd1;
      casez (op)
         8'h03: m_acc = {m_acc[0], m_acc[7:1]};
         8'hc4: m_acc = {m_acc[3:0], m_acc[7:4]};
         8'hd3: m_psw[7] = 1'b1;
         8'hd2: nb = 2'd2;
         8'h64: {nb, m_acc} = {2'd2, m_acc ^ opd};
         8'hc5: {nb, mem[opd], m_acc} = {2'd2, m_acc, mem[opd]};
         8'h80: {nb, nc, m_pc} = {2'd2, 2'd2, m_pc + {{8{opd[7]}}, opd}};
         8'b11001???: {mem[{3'b000, bank_sel, op[2:0]}], m_acc} = {m_acc, t};
         8'b01101???: m_acc = m_acc ^ t;
         8'b1100011?: {mem[p], m_acc} = {m_acc, mem[p]};
         8'b0110011?: m_acc = m_acc ^ mem[p];
         8'b1101011?: {mem[p][3:0], m_acc[3:0]} = {m_acc[3:0], mem[p][3:0]};
         8'b1001011?: begin
            s = {1'b0, m_acc} - mem[p] - m_psw[7];
            h = {1'b0, m_acc[3:0]} - mem[p][3:0] - m_psw[7];
            m_psw[2] = (m_acc[7] ^ mem[p][7]) & (m_acc[7] ^ s[7]);
            {m_psw[7], m_psw[6], m_acc} = {s[8], h[4], s[7:0]};
         end
         8'h22: begin
            m_pc = {mem[m_sp], mem[m_sp - 8'd1]} - 16'd1;
            {nc, m_sp} = {2'd2, m_sp - 8'd2};
         end
         default: ;
      endcase
      m_pc = m_pc + nb;
      m_psw[0] = ^m_acc;
      expq.push_back({m_acc, m_psw, m_sp, m_pc, nb, nc});
      {opcode, operand, instr_valid} = {op, opd, 1'b1};
      @(negedge ref_clk);
      instr_valid = 1'b0;
      for (int k = 0; k < 8 && done_r !== 1'b1; k++)
         @(negedge ref_clk);
   endtask
   always @(posedge ref_clk) begin
      #1;
      if (done_r === 1'b1) begin
         e = expq.pop_front();
         chk("acc", e[43:36], acc_r);
         chk("psw", e[35:28], psw_r);
         chk("sp", e[27:20], sp_r);
         chk("pc", e[19:4], pc_r);
         chk("bytes", e[3:2], bytes_r);
         chk("cycles", e[1:0], cycles_r);
      end
   end
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   initial begin
      #50000;
      error_cnt++;
      conclude();
   end
   initial begin
      {rst_n, instr_valid, opcode, operand} = '0;
      {m_acc, m_psw, m_sp, m_pc} = {8'h00, 8'h00, 8'h07, 16'h0000};
      foreach (mem[k]) mem[k] = 8'h00;
      i = $urandom(32'h1512);
      bank_sel = 2'($urandom);
      repeat (12) @(negedge ref_clk);
      rst_n = 1'b1;
      run(8'ha5, 8'h00);
      for (i = 0; i < 8; i++) begin
         run(8'h64, 8'($urandom));
         run(8'hc5, {3'b000, bank_sel, i[2:0]});
         run(8'h03, 8'h00);
         run(8'hc4, 8'h00);
         run(8'hd2, 8'($urandom));
      end
      for (i = 0; i < 8; i++) begin
         run({5'h19, i[2:0]}, 8'h00);
         run({5'h0d, i[2:0]}, 8'h00);
      end
      for (i = 0; i < 2; i++) begin
         run({7'h63, i[0]}, 8'h00);
         run({7'h33, i[0]}, 8'h00);
         run({7'h6b, i[0]}, 8'h00);
         run(8'hd3, 8'h00);
         run({7'h4b, i[0]}, 8'h00);
         run(8'h64, 8'($urandom));
         run({7'h4b, i[0]}, 8'h00);
      end
      run(8'h80, 8'h7f);
      run(8'h80, 8'h80);
      for (i = 6; i < 8; i++) begin
         run(8'h64, 8'($urandom));
         run(8'hc5, i[7:0]);
      end
      run(8'h22, 8'h00);
      @(negedge ref_clk);
      chk("queue", 16'd0, 16'(expq.size()));
      conclude();
   end
endmodule // tb_alxe_exec
`default_nettype wire
